/* src/rtc_wdt_ctrl.sv */
// Register front end for trim, watchdog and interrupt configuration.
// Assumes parallel bus inputs already synchronous to sys_clk.
// Operation
// - Calibration sign selects add or subtract trim
// - Strobe write reloads and restarts watchdog
// - Strobe bit clears itself after reload
// - Strobe bit always reads back zero
// - Enabled timeout drives interrupt and sets flag
// - Disabled timeout sets flag only
// - Control registers hold plain binary values
// - Trim and config reset to 00h
`timescale 1ns/1ns
module rtc_wdt_ctrl
    import rtc_wdt_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT // Shorten for simulation
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [14:0] addr, // Byte address
    input wire logic [7:0] dq_in, // Data from host
    output logic [7:0] dq_out, // Data to host
    output logic dq_oe_b, // Low while driving dq
    input wire logic chip_en_b, // Chip enable, active low
    input wire logic write_en_b, // Write enable, active low
    input wire logic out_en_b, // Output enable, active low
    input wire logic flag_clear, // Clears timeout flag
    output logic watchdog_timeout_flag, // Sticky timeout flag
    output logic irq_out // Interrupt, active high
);
    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [7:0] int_cfg_reg; // Interrupt configuration
    logic [7:0] trim_reg; // Oscillator trim
    logic [5:0] timeout_reg; // watchdog_timeout_value
    logic gate_reg; // watchdog_write_gate
    logic strobe_reg; // watchdog_strobe pending
    logic wr_seen_reg; // Write cycle already taken
    logic flag_reg; // Timeout flag
    logic irq_reg; // Interrupt output
    logic [7:0] dq_out_reg; // Read data
    logic oe_b_reg; // Data drive, active low
    wdt_if w ();

    wire logic cs = !chip_en_b;
    wire logic wr_act = cs && !write_en_b;
    wire logic wr_take = wr_act && !wr_seen_reg; // One write per bus cycle
    wire logic hit_cfg = (addr == ADDR_INT_CFG);
    wire logic hit_wdt = (addr == ADDR_WDT_CTRL);
    wire logic hit_trim = (addr == ADDR_TRIM);
    wire logic hit_any = hit_cfg || hit_wdt || hit_trim;
    wire logic rd_act = cs && write_en_b && !out_en_b && hit_any;
    wire logic watchdog_irq_enable = int_cfg_reg[WDT_IRQ_EN_BIT];
    // Strobe position always reads zero
    wire logic [7:0] wdt_rd = {1'b0, gate_reg, timeout_reg};
    wire logic [7:0] rd_data = hit_cfg ? int_cfg_reg : (hit_wdt ? wdt_rd : trim_reg);
    wire logic strobe_next = wr_take && hit_wdt && dq_in[STROBE_BIT];
    // Hardware set wins over a simultaneous clear
    wire logic flag_next = w.expire || (flag_reg && !flag_clear);

    // ****************************************************************
    // Configuration registers; values stored as raw binary
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_cfg_reg <= INT_CFG_RESET;
            trim_reg <= TRIM_RESET;
        end else begin
            if (wr_take && hit_cfg) begin
                int_cfg_reg <= dq_in & INT_CFG_MASK;
            end
            if (wr_take && hit_trim) begin
                trim_reg <= {dq_in[OSC_BIT], 1'b0, dq_in[CAL_SIGN_BIT:0]};
            end
        end
    end

    // Watchdog control; a set gate bit protects the timeout field
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            timeout_reg <= TIMEOUT_RESET;
            gate_reg <= 1'b0;
        end else if (wr_take && hit_wdt) begin
            gate_reg <= dq_in[GATE_BIT];
            if (!dq_in[GATE_BIT]) begin
                timeout_reg <= dq_in[TIMEOUT_MSB:0];
            end
        end
    end

    // Strobe lives one cycle: the core reloads on it, then it drops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    // Flag and interrupt
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            irq_reg <= flag_next && watchdog_irq_enable;
        end
    end

    // Bus cycle tracking and read data
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_seen_reg <= 1'b0;
            dq_out_reg <= 8'h00;
            oe_b_reg <= 1'b1;
        end else begin
            wr_seen_reg <= wr_act;
            dq_out_reg <= rd_act ? rd_data : 8'h00;
            oe_b_reg <= !rd_act;
        end
    end

    // ****************************************************************
    // Core hookup
    // ****************************************************************
    assign w.reload = strobe_reg;
    assign w.timeout_value = timeout_reg;
    assign w.osc_stop = trim_reg[OSC_BIT];
    assign w.cal_sign = trim_reg[CAL_SIGN_BIT];
    assign w.cal_amount = trim_reg[CAL_MSB:0];

    wdt_core #(.TICK_CYCLES(TICK_CYCLES)) u_core (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .w(w.core)
    );

    assign dq_out = dq_out_reg;
    assign dq_oe_b = oe_b_reg;
    assign watchdog_timeout_flag = flag_reg;
    assign irq_out = irq_reg;

    // Checks on the front end
    a_strobe_reload: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_next |=> strobe_reg ##1 (w.count == $past(timeout_reg)))
        else $error("strobe did not reload counter");
    a_strobe_selfclear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg |=> !strobe_reg)
        else $error("strobe bit did not clear");
    a_strobe_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (rd_act && hit_wdt) |=> (!dq_oe_b && !dq_out[STROBE_BIT]))
        else $error("strobe bit read back as one");
    a_irq_when_enabled: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (w.expire && watchdog_irq_enable) |=> (irq_out && watchdog_timeout_flag))
        else $error("enabled timeout missed interrupt");
    a_flag_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (w.expire && !watchdog_irq_enable) |=> (!irq_out && watchdog_timeout_flag))
        else $error("disabled timeout touched interrupt");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (flag_reg && !flag_clear) |=> flag_reg)
        else $error("timeout flag lost");
    a_cfg_binary: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_take && hit_cfg) |=> (int_cfg_reg == ($past(dq_in) & INT_CFG_MASK)))
        else $error("config write not stored");

    // ****************************************************************
    // Further checks on storage, gating and the interrupt path
    // ****************************************************************
    // Trim keeps oscillator, sign and amount; bit 6 is not implemented
    a_trim_stored: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_take && hit_trim) |=> (trim_reg[CAL_SIGN_BIT:0] == $past(dq_in[CAL_SIGN_BIT:0])))
        else $error("trim write not stored");
    // A set gate bit must leave the timeout untouched
    a_gate_protects: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_take && hit_wdt && dq_in[GATE_BIT]) |=> (timeout_reg == $past(timeout_reg)))
        else $error("gated write changed timeout");
    // A clear gate bit lets the timeout field through
    a_timeout_written: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_take && hit_wdt && !dq_in[GATE_BIT]) |=> (timeout_reg == $past(dq_in[5:0])))
        else $error("timeout write not stored");
    // No interrupt while the enable is low
    a_irq_needs_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !watchdog_irq_enable |=> !irq_out)
        else $error("interrupt while disabled");
    // The interrupt never stands without the flag
    a_irq_needs_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
        irq_out |-> watchdog_timeout_flag)
        else $error("interrupt without flag");
    // A held write is taken only once
    a_write_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_take |=> !wr_take)
        else $error("write taken twice");
    // Bus released one cycle after a read ends
    a_read_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !rd_act |=> (dq_oe_b && (dq_out == 8'h00)))
        else $error("bus still driven after read");
    // Strobe only follows a host write with the strobe bit set
    a_strobe_from_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strobe_reg |-> $past(wr_take && hit_wdt && dq_in[STROBE_BIT]))
        else $error("strobe without host write");
    // Reserved config bits always hold zero
    a_cfg_low_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ((int_cfg_reg & ~INT_CFG_MASK) == 8'h00))
        else $error("reserved config bits set");
    // Unimplemented trim bit always holds zero
    a_trim_gap_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !trim_reg[CAL_SIGN_BIT + 1])
        else $error("reserved trim bit set");
    // A timeout in the same cycle as a clear still sets the flag
    a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (w.expire && flag_clear) |=> watchdog_timeout_flag)
        else $error("clear beat a timeout");
    // A clear with no timeout drops the flag
    a_flag_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (flag_clear && !w.expire) |=> !watchdog_timeout_flag)
        else $error("flag not cleared");
    // Config read returns the stored byte
    a_read_cfg: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (rd_act && hit_cfg) |=> (dq_out == $past(int_cfg_reg)))
        else $error("config read wrong");
endmodule

/* src/rtc_wdt_pkg.sv */
// Shared constants for the clock watchdog, trim and interrupt control block.
// Assumes a single 250 MHz system clock and a byte-wide register map.
package rtc_wdt_pkg;
    // ****************************************************************
    // Register addresses on the 15-bit parallel address bus
    // ****************************************************************
    localparam logic [14:0] ADDR_INT_CFG = 15'h7FF6; // Watchdog/interrupt configuration
    localparam logic [14:0] ADDR_WDT_CTRL = 15'h7FF7; // Watchdog control
    localparam logic [14:0] ADDR_TRIM = 15'h7FF8; // Oscillator trim

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int WDT_IRQ_EN_BIT = 7; // watchdog_irq_enable
    localparam int ALARM_IRQ_EN_BIT = 6; // alarm_irq_enable
    localparam int PFAIL_IRQ_EN_BIT = 5; // powerfail_irq_enable
    localparam int ALARM_BACKUP_BIT = 4; // alarm_backup_enable
    localparam int INT_CFG_LSB = 2; // Lowest implemented config bit
    localparam int STROBE_BIT = 7; // watchdog_strobe
    localparam int GATE_BIT = 6; // watchdog_write_gate
    localparam int TIMEOUT_MSB = 5; // watchdog_timeout_value top bit
    localparam int OSC_BIT = 7; // Oscillator stop, 1 halts the time-base
    localparam int CAL_SIGN_BIT = 5; // Calibration sign
    localparam int CAL_MSB = 4; // Calibration amount top bit

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] INT_CFG_RESET = 8'h00; // Factory value
    localparam logic [7:0] TRIM_RESET = 8'h00; // Factory value
    localparam logic [5:0] TIMEOUT_RESET = 6'h00; // Watchdog off
    localparam logic [7:0] INT_CFG_MASK = 8'hFC; // Bits 1:0 reserved, read 0

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 4; // 250 MHz
    localparam int TICK_PERIOD_NS = 31250000; // 32 Hz time-base, 31.25 ms
    localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [23:0] CAL_STEP_CYCLES = 24'h000040; // Cycles per trim unit
endpackage

/* src/wdt_core.sv */
// Trimmed 32 Hz time-base and watchdog down-counter.
// Assumes reload is a one-cycle request from the register front end.
`timescale 1ns/1ns
module wdt_core
    import rtc_wdt_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Async reset, active low
    wdt_if.core w // Control and status
);
    // ****************************************************************
    // Time-base trim
    // ****************************************************************
    logic [23:0] div_reg; // Cycle counter inside a tick
    logic [23:0] div_next; // Next divider value
    logic [5:0] cnt_reg; // Watchdog ticks left
    logic [5:0] cnt_next; // Next count
    logic expire_reg; // Timeout pulse
    logic expire_next; // Next timeout pulse
    wire logic [23:0] tick_base = 24'(TICK_CYCLES); // Untrimmed period
    wire logic [23:0] cal_scaled = {19'h00000, w.cal_amount} * CAL_STEP_CYCLES;
    // Sign picks add or subtract; the default base dwarfs the trim so no wrap, but a 16-cycle base can wrap on subtract
    wire logic [23:0] tick_len = w.cal_sign ? tick_base - cal_scaled
                                            : tick_base + cal_scaled;
    wire logic tick = !w.osc_stop && (div_reg >= tick_len - 24'h000001);
    wire logic wdt_off = (w.timeout_value == 6'h00);

    // Divider holds while the oscillator is stopped
    assign div_next = w.osc_stop ? div_reg : (tick ? 24'h000000 : div_reg + 24'h000001);

    // Counter: strobe reload wins, zero timeout disables
    always_comb begin
        cnt_next = cnt_reg;
        expire_next = 1'b0;
        if (w.reload) begin
            cnt_next = w.timeout_value;
        end else if (wdt_off) begin
            cnt_next = 6'h00;
        end else if (cnt_reg == 6'h00) begin
            cnt_next = w.timeout_value; // Freshly enabled without a strobe
        end else if (tick) begin
            if (cnt_reg == 6'h01) begin
                expire_next = 1'b1; // Timed out, restart the period
                cnt_next = w.timeout_value;
            end else begin
                cnt_next = cnt_reg - 6'h01;
            end
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 24'h000000;
            cnt_reg <= 6'h00;
            expire_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            cnt_reg <= cnt_next;
            expire_reg <= expire_next;
        end
    end

    assign w.expire = expire_reg;
    assign w.count = cnt_reg;

    // Checks on the counter
    a_reload_loads: assert property (@(posedge sys_clk) disable iff (!rst_b)
        w.reload |=> (cnt_reg == $past(w.timeout_value)))
        else $error("reload did not load timeout");
    a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wdt_off |=> !expire_reg)
        else $error("expire while watchdog disabled");
    a_stopped_no_tick: assert property (@(posedge sys_clk) disable iff (!rst_b)
        w.osc_stop |=> (div_reg == $past(div_reg)))
        else $error("divider moved while stopped");
    a_expire_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        expire_reg |-> ##1 !expire_reg ##0 (cnt_reg == $past(w.timeout_value)))
        else $error("expire longer than one cycle");
endmodule

/* src/wdt_if.sv */
// Carrier between the register front end and the watchdog core.
// Assumes both ends share sys_clk.
`timescale 1ns/1ns
interface wdt_if;
    logic reload; // Strobe pending: reload counter
    logic [5:0] timeout_value; // Programmed timeout in ticks
    logic osc_stop; // Time-base halted
    logic cal_sign; // 1 shortens the tick period
    logic [4:0] cal_amount; // Trim magnitude
    logic expire; // One-cycle timeout pulse
    logic [5:0] count; // Ticks left
    modport ctrl (output reload, output timeout_value, output osc_stop,
                  output cal_sign, output cal_amount, input expire, input count);
    modport core (input reload, input timeout_value, input osc_stop,
                  input cal_sign, input cal_amount, output expire, output count);
endinterface

/* tb/host_bus_model.sv */
// Host processor model that drives the parallel register bus.
// Assumes the block samples its bus inputs on rising sys_clk edges.
`timescale 1ns/1ns
module host_bus_model (
    input wire logic sys_clk, // System clock
    input wire logic [7:0] dq_out, // Data from block
    input wire logic dq_oe_b, // Low while block drives
    output logic [14:0] addr, // Byte address
    output logic [7:0] dq_in, // Data to block
    output logic chip_en_b, // Chip enable, active low
    output logic write_en_b, // Write enable, active low
    output logic out_en_b // Output enable, active low
);
    // Idle bus from time zero
    initial begin
        addr = 15'h0000;
        dq_in = 8'hFF;
        chip_en_b = 1'b1;
        write_en_b = 1'b1;
        out_en_b = 1'b1;
    end
    // ************************************************************
    // Bus cycles, changed only at falling edges
    // ************************************************************
    // Write held across one rising edge; the next call gives the gap
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        dq_in = d;
        chip_en_b = 1'b0;
        write_en_b = 1'b0;
        @(negedge sys_clk);
        chip_en_b = 1'b1;
        write_en_b = 1'b1;
        // Released data inverted so a stale byte never looks valid
        dq_in = ~d;
    endtask
    // Read held until the answer one cycle after the sampling edge
    task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic oe_b);
        @(negedge sys_clk);
        addr = a;
        chip_en_b = 1'b0;
        out_en_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        d = dq_out;
        oe_b = dq_oe_b;
        chip_en_b = 1'b1;
        out_en_b = 1'b1;
    endtask
endmodule

/* tb/rtc_watchdog_interrupt_control_test.sv */
// Self-checking bench for the watchdog, trim and interrupt control block.
// Assumes the host model drives the bus; tick period shortened to 16 cycles.
`timescale 1ns/1ns
module rtc_watchdog_interrupt_control_test;
    import rtc_wdt_pkg::*;
    typedef struct packed {logic [14:0] a; logic [7:0] wd; logic [7:0] rd; logic oe;} row_t;
    logic sys_clk = 1'b0; // System clock
    logic rst_b = 1'b0; // Reset, active low
    logic flag_clear = 1'b0; // Flag clear request
    logic [14:0] addr; // Bus address
    logic [7:0] dq_in; // Host data
    logic chip_en_b; // Chip enable
    logic write_en_b; // Write enable
    logic out_en_b; // Output enable
    logic [7:0] dq_out; // Block data
    logic dq_oe_b; // Block drive enable
    logic watchdog_timeout_flag; // Sticky flag
    logic irq_out; // Interrupt
    logic [7:0] rdat; // Read result
    logic roe_b; // Drive enable seen at read
    int error_cnt = 0; // Mismatches
    int checks = 0; // Comparisons
    // Write data, expected read-back and drive enable per register
    row_t rows [0:7] = '{
        '{ADDR_TRIM, 8'hDF, 8'h9F, 1'b0}, '{ADDR_TRIM, 8'h25, 8'h25, 1'b0},
        '{ADDR_INT_CFG, 8'hFF, 8'hFC, 1'b0}, '{ADDR_INT_CFG, 8'h80, 8'h80, 1'b0},
        '{ADDR_WDT_CTRL, 8'hBF, 8'h3F, 1'b0}, '{ADDR_WDT_CTRL, 8'hC5, 8'h7F, 1'b0},
        '{ADDR_WDT_CTRL, 8'h00, 8'h00, 1'b0}, '{15'h7FF9, 8'h12, 8'h00, 1'b1}};
    rtc_wdt_ctrl #(.TICK_CYCLES(16)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .chip_en_b(chip_en_b),
        .write_en_b(write_en_b), .out_en_b(out_en_b), .flag_clear(flag_clear),
        .watchdog_timeout_flag(watchdog_timeout_flag), .irq_out(irq_out));
    host_bus_model host (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_b(dq_oe_b),
        .addr(addr), .dq_in(dq_in), .chip_en_b(chip_en_b), .write_en_b(write_en_b),
        .out_en_b(out_en_b));
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bounded wait; stops early once the flag shows
    task automatic wait_flag(input int n);
        for (int i = 0; i < n && watchdog_timeout_flag !== 1'b1; i++) @(negedge sys_clk);
        if (watchdog_timeout_flag !== 1'b1) begin
            error_cnt++;
            $display("Error wait_flag expected 1 seen %b", watchdog_timeout_flag);
            end_sim();
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;
        // Table rows: write, then read back through the same bus
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].wd);
            host.rd(rows[i].a, rdat, roe_b);
            chk("read_back", rows[i].rd, rdat);
            chk("read_drive_b", {7'h00, rows[i].oe}, {7'h00, roe_b});
        end
        // Second reset mid-run restores factory values
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        chk("flag_after_reset", 8'h00, {7'h00, watchdog_timeout_flag});
        host.rd(ADDR_TRIM, rdat, roe_b);
        chk("trim_reset", TRIM_RESET, rdat);
        host.rd(ADDR_INT_CFG, rdat, roe_b);
        chk("config_reset", INT_CFG_RESET, rdat);
        // Strobing faster than the timeout keeps the flag down
        host.wr(ADDR_INT_CFG, 8'h80);
        repeat (12) begin
            host.wr(ADDR_WDT_CTRL, 8'h82);
            repeat (8) @(negedge sys_clk);
            chk("flag_while_strobed", 8'h00, {7'h00, watchdog_timeout_flag});
        end
        // Enabled timeout: flag and interrupt together
        wait_flag(50);
        @(negedge sys_clk);
        chk("flag_enabled", 8'h01, {7'h00, watchdog_timeout_flag});
        chk("irq_enabled", 8'h01, {7'h00, irq_out});
        // Disabled interrupt: flag only
        host.wr(ADDR_INT_CFG, 8'h00);
        flag_clear = 1'b1;
        @(negedge sys_clk);
        flag_clear = 1'b0;
        wait_flag(50);
        repeat (2) @(negedge sys_clk);
        chk("flag_disabled", 8'h01, {7'h00, watchdog_timeout_flag});
        chk("irq_disabled", 8'h00, {7'h00, irq_out});
        // Zero timeout switches the watchdog off
        host.wr(ADDR_WDT_CTRL, 8'h80);
        flag_clear = 1'b1;
        @(negedge sys_clk);
        flag_clear = 1'b0;
        repeat (100) @(negedge sys_clk);
        chk("flag_zero_timeout", 8'h00, {7'h00, watchdog_timeout_flag});
        end_sim();
    end
endmodule
